// ### rtl/bdsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdsc_params.svh"

// Overview of operation
// - drive supply regulated by a monitor whose level is the target setting.
// - charge source off once supply crosses target; current set by a setting.
// - regulation off at power-up with its flag set; active once host clears it.
// - with charge-off-in-listen set, charging stops after each burst completes.
// - a charge-restart request turns charging back on after that stop.
// - ready status shows supply reached and a new burst may start.
// - restart request still set at burst start keeps charging on afterwards.
// - regulation-off flag overrides charge-off-in-listen and restart request.
// - excitation mode picked by the burst input mode field; only mode 0 is built, others never arm.
// - burst enabled first; outputs move only from next falling edge.
// - mode 0 clocks from input two, enabled by the burst command request.
// - mode 0 burst starts at first falling edge of input two after enable.
// - pulses counted falling edge to falling edge of input two.
// - burst ends at programmed count or when command request is cleared.
// - during burst, bridge outputs follow input one and input two.
// - re-arm needs command request high, low, then high again.
// - pulse count zero gives continuous pulses until host ends burst.
module bdsc_top
    import bdsc_pkg::*;
#(
    parameter int PULSE_W = `BDSC_PULSE_W,
    parameter int TARGET_W = `BDSC_TARGET_W,
    parameter int CURRENT_W = `BDSC_CURRENT_W
) (
    // system clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // link clock
    input wire logic clk_link,
    // burst configuration
    input wire logic [`BDSC_MODE_W-1:0] burst_input_mode,
    input wire logic burst_command_request,
    input wire logic [PULSE_W-1:0] burst_pulse_count,
    // drive supply configuration
    input wire logic drive_supply_regulation_off,
    input wire logic charge_off_in_listen,
    input wire logic charge_restart_request,
    input wire logic [TARGET_W-1:0] drive_supply_target,
    input wire logic [CURRENT_W-1:0] drive_supply_charge_current,
    // analog monitor
    input wire logic drive_supply_at_target,
    // host pins
    input wire logic control_input_one,
    input wire logic control_input_two,
    // bridge
    output logic bridge_output_a,
    output logic bridge_output_b,
    // drive supply control and status
    output logic charge_enable,
    output logic [TARGET_W-1:0] target_select,
    output logic [CURRENT_W-1:0] current_select,
    output logic drive_supply_ready,
    output logic regulation_off_status,
    output logic burst_active
);

    // ----------------------------------------
    // reset release
    // ----------------------------------------
    logic rst_sys_n;
    logic rst_link_n;
    bdsc_sync #(.W(1)) u_rst_sys (.clk(clk_sys), .rst_n(rst_n), .d(1'b1), .q(rst_sys_n));
    bdsc_sync #(.W(1)) u_rst_link (.clk(clk_link), .rst_n(rst_n), .d(1'b1), .q(rst_link_n));

    // ----------------------------------------
    // system side: arm request
    // ----------------------------------------
    logic arm_q;
    logic [PULSE_W-1:0] pulse_q;

    // only the spi-triggered mode is built; others never arm
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            arm_q <= 1'b0;
            pulse_q <= '0;
        end else begin
            arm_q <= burst_command_request && (burst_input_mode == `BDSC_IO_MODE_SPI);
            pulse_q <= burst_pulse_count;
        end
    end

    // ----------------------------------------
    // crossings
    // ----------------------------------------
    logic arm_l;
    logic io1_s;
    logic io2_s;
    logic done_tog_q;
    logic done_tog_s;
    logic burst_q;
    logic above_s;
    bdsc_sync #(.W(1)) u_arm (.clk(clk_link), .rst_n(rst_link_n), .d(arm_q), .q(arm_l));
    // pins idle high thanks to pull-ups, but reset low here is harmless
    bdsc_sync #(.W(2)) u_pins (.clk(clk_link), .rst_n(rst_link_n),
        .d({control_input_one, control_input_two}), .q({io1_s, io2_s}));
    bdsc_sync #(.W(1)) u_done (.clk(clk_sys), .rst_n(rst_sys_n), .d(done_tog_q), .q(done_tog_s));
    bdsc_sync #(.W(1)) u_busy (.clk(clk_sys), .rst_n(rst_sys_n), .d(burst_q), .q(burst_active));
    bdsc_sync #(.W(1)) u_above (.clk(clk_sys), .rst_n(rst_sys_n), .d(drive_supply_at_target), .q(above_s));

    // ----------------------------------------
    // link side: burst engine
    // ----------------------------------------
    bdsc_link_state_t state_q;
    bdsc_link_state_t state_d;
    logic io2_prev_q;
    logic io2_fall;
    logic [PULSE_W-1:0] cnt_q;
    logic [PULSE_W-1:0] cnt_inc;
    logic [PULSE_W-1:0] limit_q;
    logic count_hit;

    assign io2_fall = io2_prev_q && !io2_s;
    assign cnt_inc = cnt_q + 1'b1;
    // zero limit never hits: continuous burst
    assign count_hit = io2_fall && (limit_q != `BDSC_PULSE_CONT) && (cnt_inc == limit_q);

    always_comb begin
        state_d = state_q;
        case (state_q)
            L_IDLE: begin
                if (arm_l) begin
                    state_d = L_ARMED;
                end
            end
            L_ARMED: begin
                if (!arm_l) begin
                    state_d = L_IDLE;
                end else if (io2_fall) begin
                    state_d = L_BURST;
                end
            end
            L_BURST: begin
                if (!arm_l) begin
                    state_d = L_IDLE;
                end else if (count_hit) begin
                    state_d = L_WAIT_LOW;
                end
            end
            L_WAIT_LOW: begin
                if (!arm_l) begin
                    state_d = L_IDLE;
                end
            end
            default: begin
                state_d = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_link or negedge rst_link_n) begin
        if (!rst_link_n) begin
            state_q <= L_IDLE;
            io2_prev_q <= 1'b0;
        end else begin
            state_q <= state_d;
            io2_prev_q <= io2_s;
        end
    end

    // count and limit; the limit is sampled as the arm level lands,
    // so the host must hold the count steady while it requests a burst
    always_ff @(posedge clk_link or negedge rst_link_n) begin
        if (!rst_link_n) begin
            cnt_q <= '0;
            limit_q <= '0;
        end else begin
            if (state_q == L_IDLE) begin
                limit_q <= pulse_q;
            end
            if (state_q != L_BURST) begin
                cnt_q <= '0;
            end else if (io2_fall) begin
                cnt_q <= cnt_inc;
            end
        end
    end

    // outputs follow the pins only while bursting
    always_ff @(posedge clk_link or negedge rst_link_n) begin
        if (!rst_link_n) begin
            bridge_output_a <= 1'b0;
            bridge_output_b <= 1'b0;
            burst_q <= 1'b0;
        end else begin
            bridge_output_a <= (state_d == L_BURST) && io1_s;
            bridge_output_b <= (state_d == L_BURST) && io2_s;
            burst_q <= (state_d == L_BURST);
        end
    end

    // burst end event handed over as a toggle
    always_ff @(posedge clk_link or negedge rst_link_n) begin
        if (!rst_link_n) begin
            done_tog_q <= 1'b0;
        end else if (state_q == L_BURST && state_d != L_BURST) begin
            done_tog_q <= !done_tog_q;
        end
    end

    // ----------------------------------------
    // system side: drive supply control
    // ----------------------------------------
    logic reg_off_q;
    logic done_prev_q;
    logic done_seen;
    logic busy_prev_q;
    logic restart_prev_q;
    logic restart_rise;
    logic restart_at_start_q;
    logic inhibit_q;

    assign done_seen = done_tog_s ^ done_prev_q;
    assign restart_rise = charge_restart_request && !restart_prev_q;

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            reg_off_q <= `BDSC_REG_OFF_RST;
            done_prev_q <= 1'b0;
            busy_prev_q <= 1'b0;
            restart_prev_q <= 1'b0;
        end else begin
            reg_off_q <= drive_supply_regulation_off;
            done_prev_q <= done_tog_s;
            busy_prev_q <= burst_active;
            restart_prev_q <= charge_restart_request;
        end
    end

    // request still high as the burst starts means the host skipped the clear
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            restart_at_start_q <= 1'b0;
        end else if (burst_active && !busy_prev_q) begin
            restart_at_start_q <= charge_restart_request;
        end
    end

    // listen inhibit; the burst-end set wins over a restart in the same cycle
    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            inhibit_q <= 1'b0;
        end else if (reg_off_q) begin
            inhibit_q <= 1'b0;
        end else if (done_seen && charge_off_in_listen && !restart_at_start_q) begin
            inhibit_q <= 1'b1;
        end else if (restart_rise) begin
            inhibit_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sys_n) begin
        if (!rst_sys_n) begin
            charge_enable <= 1'b0;
            drive_supply_ready <= 1'b0;
            regulation_off_status <= `BDSC_REG_OFF_RST;
            target_select <= '0;
            current_select <= '0;
        end else begin
            charge_enable <= !reg_off_q && !inhibit_q && !above_s;
            drive_supply_ready <= above_s && !reg_off_q;
            regulation_off_status <= reg_off_q;
            target_select <= drive_supply_target;
            current_select <= drive_supply_charge_current;
        end
    end

    // ----------------------------------------
    // checks, link side
    // ----------------------------------------
    sequence s_armed_fall;
        state_q == L_ARMED && arm_l && io2_fall;
    endsequence
    sequence s_last_pulse;
        state_q == L_BURST && arm_l && count_hit;
    endsequence
    property p_idle_outputs;
        @(posedge clk_link) disable iff (!rst_link_n)
        state_q != L_BURST |-> !bridge_output_a && !bridge_output_b;
    endproperty
    a_idle_outputs: assert property (p_idle_outputs) else $error("bridge moved outside a burst");
    property p_start_on_fall;
        @(posedge clk_link) disable iff (!rst_link_n)
        s_armed_fall |=> state_q == L_BURST;
    endproperty
    a_start_on_fall: assert property (p_start_on_fall) else $error("burst did not start on fall");
    property p_no_early_start;
        @(posedge clk_link) disable iff (!rst_link_n)
        (state_q == L_ARMED && !io2_fall) |=> state_q != L_BURST;
    endproperty
    a_no_early_start: assert property (p_no_early_start) else $error("burst started without fall");
    property p_follow_pins;
        @(posedge clk_link) disable iff (!rst_link_n)
        state_d == L_BURST |=> bridge_output_a == $past(io1_s) && bridge_output_b == $past(io2_s);
    endproperty
    a_follow_pins: assert property (p_follow_pins) else $error("bridge not following pins");

    property p_count_end;
        @(posedge clk_link) disable iff (!rst_link_n)
        s_last_pulse |=> state_q == L_WAIT_LOW ##1 !bridge_output_a && !bridge_output_b;
    endproperty
    a_count_end: assert property (p_count_end) else $error("burst overran its count");

    property p_request_end;
        @(posedge clk_link) disable iff (!rst_link_n)
        (state_q == L_BURST && !arm_l) |=> state_q == L_IDLE;
    endproperty
    a_request_end: assert property (p_request_end) else $error("request clear did not end burst");

    property p_rearm;
        @(posedge clk_link) disable iff (!rst_link_n)
        (state_q == L_WAIT_LOW && arm_l) |=> state_q == L_WAIT_LOW;
    endproperty
    a_rearm: assert property (p_rearm) else $error("re-armed without low phase");

    property p_continuous;
        @(posedge clk_link) disable iff (!rst_link_n)
        (state_q == L_BURST && arm_l && limit_q == `BDSC_PULSE_CONT) |=> state_q == L_BURST;
    endproperty
    a_continuous: assert property (p_continuous) else $error("continuous burst stopped");

    // ----------------------------------------
    // checks, system side
    // ----------------------------------------
    property p_reg_off;
        @(posedge clk_sys) disable iff (!rst_sys_n)
        reg_off_q |=> !charge_enable && !inhibit_q;
    endproperty
    a_reg_off: assert property (p_reg_off) else $error("charging while regulation off");

    property p_listen_stop;
        @(posedge clk_sys) disable iff (!rst_sys_n)
        (!reg_off_q && done_seen && charge_off_in_listen && !restart_at_start_q) |=> inhibit_q ##1 !charge_enable;
    endproperty
    a_listen_stop: assert property (p_listen_stop) else $error("charging kept after burst");

    property p_restart;
        @(posedge clk_sys) disable iff (!rst_sys_n)
        (inhibit_q && restart_rise && !done_seen && !reg_off_q) |=> !inhibit_q;
    endproperty
    a_restart: assert property (p_restart) else $error("restart did not clear inhibit");

    property p_restart_held;
        @(posedge clk_sys) disable iff (!rst_sys_n)
        (done_seen && restart_at_start_q && !inhibit_q) |=> !inhibit_q;
    endproperty
    a_restart_held: assert property (p_restart_held) else $error("inhibit despite held restart");

    property p_target_cut;
        @(posedge clk_sys) disable iff (!rst_sys_n)
        above_s |=> !charge_enable && (drive_supply_ready == !$past(reg_off_q));
    endproperty
    a_target_cut: assert property (p_target_cut) else $error("charging above target");

endmodule

`default_nettype wire

// ### common/bdsc_params.svh
`ifndef BDSC_PARAMS_SVH
`define BDSC_PARAMS_SVH

// ----------------------------------------
// widths of the settings
// ----------------------------------------
`define BDSC_PULSE_W 6
`define BDSC_TARGET_W 4
`define BDSC_CURRENT_W 2
`define BDSC_MODE_W 2

// ----------------------------------------
// encodings and reset values
// ----------------------------------------
`define BDSC_IO_MODE_SPI 2'h0
`define BDSC_REG_OFF_RST 1'b1
`define BDSC_PULSE_CONT 6'h00

`endif

// ### common/bdsc_pkg.sv
`default_nettype none

package bdsc_pkg;

    // burst engine states, link side
    typedef enum logic [1:0] {
        L_IDLE,
        L_ARMED,
        L_BURST,
        L_WAIT_LOW
    } bdsc_link_state_t;

endpackage

`default_nettype wire

// ### rtl/bdsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser; also serves as reset release when d is tied high
module bdsc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

`default_nettype wire

// ### test/bdsc_host_pins.sv
`timescale 1ns/1ps
`default_nettype none

// host side of the burst pins: a free burst clock on pin two while run is high
module bdsc_host_pins #(
    parameter int HALF_NS = 1000
) (
    // control from the bench
    input wire logic run,
    // host pins
    output logic pin_one,
    output logic pin_two,
    // falling edges of pin two so far
    output int falls
);
    // ----------------------------------------
    // pin sequencing
    // ----------------------------------------
    // pins rest high, as the pull-ups leave them; one stays opposite two in a burst
    initial begin
        pin_one = 1'b1;
        pin_two = 1'b1;
        falls = 0;
        forever begin
            wait (run === 1'b1);
            while (run === 1'b1) begin
                #(HALF_NS);
                pin_two = 1'b0;
                pin_one = 1'b1;
                falls = falls + 1;
                #(HALF_NS);
                pin_two = 1'b1;
                pin_one = 1'b0;
            end
            pin_one = 1'b1;
        end
    end
endmodule

`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys, clk_link, rst_n;
    logic [1:0] mode;
    logic cmd_req, reg_off, listen, restart, at_target, run;
    logic [5:0] pulse_cnt;
    logic [3:0] tgt;
    logic [1:0] cur;
    logic pin_one, pin_two;
    logic bridge_output_a, bridge_output_b, charge_enable, drive_supply_ready;
    logic regulation_off_status, burst_active;
    logic [3:0] target_select;
    logic [1:0] current_select;
    int falls;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    // ----------------------------------------
    // clocks, instances
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // link clock offset so its edges never line up with the system clock
    initial begin
        clk_link = 1'b0;
        #13;
        forever #32 clk_link = ~clk_link;
    end

    bdsc_top bdsc_top_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_link(clk_link),
        .burst_input_mode(mode), .burst_command_request(cmd_req), .burst_pulse_count(pulse_cnt),
        .drive_supply_regulation_off(reg_off), .charge_off_in_listen(listen),
        .charge_restart_request(restart), .drive_supply_target(tgt), .drive_supply_charge_current(cur),
        .drive_supply_at_target(at_target), .control_input_one(pin_one), .control_input_two(pin_two),
        .bridge_output_a(bridge_output_a), .bridge_output_b(bridge_output_b),
        .charge_enable(charge_enable), .target_select(target_select), .current_select(current_select),
        .drive_supply_ready(drive_supply_ready), .regulation_off_status(regulation_off_status),
        .burst_active(burst_active)
    );

    bdsc_host_pins bdsc_host_pins_i (.run(run), .pin_one(pin_one), .pin_two(pin_two), .falls(falls));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_active(input logic lvl, input int lim);
        int n;
        n = 0;
        while (burst_active !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        check("burst_active", burst_active, lvl);
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // arm, start the pin clock, check following, then for nonzero nf wait for the count to end
    task automatic burst(input logic [5:0] cnt, input int nf);
        int f0;
        @(posedge clk_sys);
        pulse_cnt <= cnt;
        cmd_req <= 1'b1;
        settle(10);
        check("bridge_a armed", bridge_output_a, 1'b0);
        check("bridge_b armed", bridge_output_b, 1'b0);
        check("active armed", burst_active, 1'b0);
        f0 = falls;
        @(posedge clk_sys);
        run <= 1'b1;
        wait_active(1'b1, 40);
        check("falls at start", 8'(falls - f0), 8'h01);
        @(negedge pin_two);
        #600;
        check("bridge_b low", bridge_output_b, pin_two);
        check("bridge_a high", bridge_output_a, pin_one);
        @(posedge pin_two);
        #600;
        check("bridge_b high", bridge_output_b, pin_two);
        check("bridge_a low", bridge_output_a, pin_one);
        if (nf > 0) begin
            wait_active(1'b0, 30 * nf);
            check("falls at end", 8'(falls - f0), 8'(nf + 1));
            settle(2);
            check("bridge_a after", bridge_output_a, 1'b0);
        end
    endtask

    // ----------------------------------------
    // timeout
    // ----------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            test_done();
        end
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        mode = 2'h0;
        cmd_req = 1'b0;
        pulse_cnt = 6'h04;
        reg_off = 1'b1;
        listen = 1'b0;
        restart = 1'b0;
        tgt = 4'h0;
        cur = 2'h0;
        at_target = 1'b0;
        run = 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(5);
        check("reg_off_status", regulation_off_status, 1'b1);
        check("charge reset", charge_enable, 1'b0);
        check("bridge_a idle", bridge_output_a, 1'b0);
        @(posedge clk_sys);
        reg_off <= 1'b0;
        tgt <= 4'ha;
        cur <= 2'h2;
        settle(6);
        check("charge on", charge_enable, 1'b1);
        check("target_select", target_select, 4'ha);
        check("current_select", current_select, 2'h2);
        check("ready low", drive_supply_ready, 1'b0);
        @(posedge clk_sys);
        at_target <= 1'b1;
        settle(6);
        check("charge at target", charge_enable, 1'b0);
        check("ready high", drive_supply_ready, 1'b1);
        @(posedge clk_sys);
        at_target <= 1'b0;
        listen <= 1'b1;
        settle(6);
        check("charge recharging", charge_enable, 1'b1);
        burst(6'h04, 4);
        settle(8);
        check("charge after burst", charge_enable, 1'b0);
        settle(60);
        check("no rearm", burst_active, 1'b0);
        @(posedge clk_sys);
        run <= 1'b0;
        restart <= 1'b1;
        cmd_req <= 1'b0;
        settle(6);
        check("charge restarted", charge_enable, 1'b1);
        settle(30);
        burst(6'h02, 2);
        settle(8);
        check("charge kept", charge_enable, 1'b1);
        @(posedge clk_sys);
        run <= 1'b0;
        restart <= 1'b0;
        cmd_req <= 1'b0;
        settle(30);
        burst(6'h00, 0);
        settle(100);
        check("continuous", burst_active, 1'b1);
        @(posedge clk_sys);
        cmd_req <= 1'b0;
        wait_active(1'b0, 20);
        @(posedge clk_sys);
        run <= 1'b0;
        settle(30);
        @(posedge clk_sys);
        mode <= 2'h1;
        cmd_req <= 1'b1;
        run <= 1'b1;
        settle(60);
        check("mode one idle", burst_active, 1'b0);
        @(posedge clk_sys);
        run <= 1'b0;
        cmd_req <= 1'b0;
        mode <= 2'h0;
        reg_off <= 1'b1;
        restart <= 1'b1;
        at_target <= 1'b1;
        settle(6);
        check("charge reg off", charge_enable, 1'b0);
        check("ready reg off", drive_supply_ready, 1'b0);
        check("status reg off", regulation_off_status, 1'b1);
        test_done();
    end
endmodule

`default_nettype wire
